// file: hdl/fan_pwm.v
// one fan drive output, duty over 255
`timescale 1ns/1ps
`include "fan_thermal_regs.vh"

module fan_pwm (
  input wire mclk, // system clock
  input wire rst_n, // async reset, active low
  input wire [7:0] duty, // high time in 1/255 steps
  output reg drive // drive pin level
);

reg [7:0] phase;

// ==================================================
// 255 phases so that all ones gives a steady high
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    phase <= 8'h00;
    drive <= 1'b1;
  end
  else
  begin
    phase <= (phase == `PWM_TOP) ? 8'h00 : phase + 8'h01;
    drive <= (phase < duty);
  end
end

endmodule // fan_pwm

// file: hdl/fan_thermal_control_alerts.v
// fan control, smart fan loops, temperature readout and alert logic
`timescale 1ns/1ps
`include "fan_thermal_regs.vh"

module fan_thermal_control_alerts #(
  parameter [23:0] STEP_CYCLES = `STEP_CYCLES
) (
  input wire mclk, // system clock, 40 MHz
  input wire rst_n, // async reset, active low
  input wire [7:0] reg_addr, // register index
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [7:0] reg_rdata, // read data, next cycle
  input wire [4:0] tach_in, // tach pins
  input wire conv_done, // new readings valid
  input wire [7:0] volt_value, // monitored voltage
  input wire [7:0] temp1_value, // sensor one, whole degrees
  input wire [8:0] temp2_value, // sensor two, half degrees
  input wire [8:0] temp3_value, // sensor three, half degrees
  output wire [4:0] fan_drive_out, // drive pins
  output reg sys_mgmt_interrupt_out_n, // event pulse, low
  output reg irq_out, // level interrupt
  output reg [2:0] fan_full_warn // loop at full, still hot
);

// ==================================================
// helpers
function [9:0] ext;
  input [7:0] v;
  input sgn;
  begin
    ext = sgn ? {{2{v[7]}}, v} : {2'b00, v};
  end
endfunction

function above;
  input [7:0] v;
  input [7:0] tg;
  input [7:0] tl;
  input sgn;
  begin
    above = $signed(ext(v, sgn)) > $signed(ext(tg, sgn) + {2'b00, tl});
  end
endfunction

function below;
  input [7:0] v;
  input [7:0] tg;
  input [7:0] tl;
  input sgn;
  begin
    below = $signed(ext(v, sgn) + {2'b00, tl}) < $signed(ext(tg, sgn));
  end
endfunction

// ==================================================
// state
reg [7:0] duty [0:4];
reg [2:0] div_sel [0:4];
reg [7:0] sf_target [0:2];
reg [7:0] sf_tol [0:2];
reg [7:0] sf_start [0:2];
reg [7:0] sf_floor [0:2];
reg [7:0] ot_lim [0:2];
reg [7:0] hyst_limit [0:2];
reg [5:0] sf_mode;
reg [2:0] engaged;
reg [2:0] tmode;
reg [7:0] lim_a;
reg [7:0] lim_b;
reg [7:0] volt_hi;
reg [7:0] volt_lo;
reg [7:0] volt_rd;
reg [7:0] t1_rd;
reg [8:0] t2_rd;
reg [8:0] t3_rd;
reg [2:0] hot;
reg v_out;
reg [1:0] fan_over;
reg [2:0] stat_a;
reg [2:0] stat_b;
reg rd_a;
reg rd_b;
reg [23:0] step_cnt;
reg [10:0] base_cnt;
wire [7:0] fan_cnt [0:4];
wire [7:0] tdeg [0:2];
wire step_tick = (step_cnt == STEP_CYCLES - 24'h1);
wire base_tick = (base_cnt == `TACH_TICK_CYCLES - 1);
integer k;
integer m;
integer r;

// sensor one is whole degrees, others drop the half bit
assign tdeg[0] = t1_rd;
assign tdeg[1] = t2_rd[8:1];
assign tdeg[2] = t3_rd[8:1];

// ==================================================
// tach channels and drive outputs
genvar g;
generate
  for (g = 0; g < 5; g = g + 1)
  begin : chan
    tach_counter tach (
      .mclk(mclk),
      .rst_n(rst_n),
      .base_tick(base_tick),
      .div_sel(div_sel[g]),
      .tach_pin(tach_in[g]),
      .count(fan_cnt[g])
    );
    fan_pwm pwm (
      .mclk(mclk),
      .rst_n(rst_n),
      .duty(duty[g]),
      .drive(fan_drive_out[g])
    );
  end
endgenerate

// ==================================================
// time bases
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    step_cnt <= 24'h0;
    base_cnt <= 11'h0;
  end
  else
  begin
    step_cnt <= step_tick ? 24'h0 : step_cnt + 24'h1;
    base_cnt <= base_tick ? 11'h0 : base_cnt + 11'h1;
  end
end

// ==================================================
// configuration writes and smart fan loops
// hardware steps land after software writes, so a loop wins
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    for (k = 0; k < 5; k = k + 1)
    begin
      duty[k] <= `DUTY_RESET;
      div_sel[k] <= `DIV_RESET;
    end
    for (k = 0; k < 3; k = k + 1)
    begin
      sf_target[k] <= 8'h00;
      sf_tol[k] <= 8'h00;
      sf_start[k] <= 8'h00;
      sf_floor[k] <= 8'h00;
      ot_lim[k] <= 8'h7F;
      hyst_limit[k] <= 8'h7F;
    end
    sf_mode <= 6'h00;
    engaged <= 3'h0;
    fan_full_warn <= 3'h0;
    tmode <= 3'h0;
    lim_a <= 8'hFF;
    lim_b <= 8'hFF;
    volt_hi <= 8'hFF;
    volt_lo <= 8'h00;
  end
  else
  begin
    if (reg_wr)
    begin
      case (reg_addr)
        `R_DUTY1: duty[0] <= reg_wdata;
        `R_DUTY2: duty[1] <= reg_wdata;
        `R_DUTY3: duty[2] <= reg_wdata;
        `R_DUTY4: duty[3] <= reg_wdata;
        `R_DUTY5: duty[4] <= reg_wdata;
        `R_DIV_A:
        begin
          div_sel[0] <= reg_wdata[2:0];
          div_sel[1] <= reg_wdata[6:4];
        end
        `R_DIV_B:
        begin
          div_sel[2] <= reg_wdata[2:0];
          div_sel[3] <= reg_wdata[6:4];
        end
        `R_DIV_C: div_sel[4] <= reg_wdata[2:0];
        `R_SF_MODE: sf_mode <= reg_wdata[5:0];
        `R_LIM_A: lim_a <= reg_wdata;
        `R_LIM_B: lim_b <= reg_wdata;
        `R_VHI: volt_hi <= reg_wdata;
        `R_VLO: volt_lo <= reg_wdata;
        `R_TMODE: tmode <= reg_wdata[2:0];
        default:
        begin
          for (k = 0; k < 3; k = k + 1)
          begin
            if (reg_addr == `R_TARGET + k)
              sf_target[k] <= reg_wdata;
            if (reg_addr == `R_TOL + k)
              sf_tol[k] <= reg_wdata;
            if (reg_addr == `R_START + k)
              sf_start[k] <= reg_wdata;
            if (reg_addr == `R_FLOOR + k)
              sf_floor[k] <= reg_wdata;
            if (reg_addr == `R_OT_LIM + k)
              ot_lim[k] <= reg_wdata;
            if (reg_addr == `R_HYST + k)
              hyst_limit[k] <= reg_wdata;
          end
        end
      endcase
    end
    for (k = 0; k < 3; k = k + 1)
    begin
      if (step_tick)
      begin
        case (sf_mode[2*k +: 2])
          `SF_TEMP:
          begin
            if (!engaged[k])
            begin
              fan_full_warn[k] <= 1'b0;
              if (above(tdeg[k], sf_target[k], sf_tol[k], 1'b1))
              begin
                engaged[k] <= 1'b1;
                duty[k] <= sf_start[k];
              end
              else
                duty[k] <= sf_floor[k];
            end
            else if (above(tdeg[k], sf_target[k], sf_tol[k], 1'b1))
            begin
              if (duty[k] == 8'hFF)
                fan_full_warn[k] <= 1'b1;
              else
                duty[k] <= duty[k] + 8'h01;
            end
            else if (below(tdeg[k], sf_target[k], sf_tol[k], 1'b1))
            begin
              fan_full_warn[k] <= 1'b0;
              // at the floor the loop re-arms for the start jump
              if (duty[k] > sf_floor[k])
                duty[k] <= duty[k] - 8'h01;
              else
                engaged[k] <= 1'b0;
            end
            else
              fan_full_warn[k] <= 1'b0;
          end
          `SF_COUNT:
          begin
            engaged[k] <= 1'b0;
            fan_full_warn[k] <= 1'b0;
            if (above(fan_cnt[k], sf_target[k], sf_tol[k], 1'b0))
            begin
              if (duty[k] != 8'hFF)
                duty[k] <= duty[k] + 8'h01;
            end
            else if (below(fan_cnt[k], sf_target[k], sf_tol[k], 1'b0))
            begin
              if (duty[k] != 8'h00)
                duty[k] <= duty[k] - 8'h01;
            end
            else
              duty[k] <= duty[k];
          end
          default:
          begin
            engaged[k] <= 1'b0;
            fan_full_warn[k] <= 1'b0;
          end
        endcase
      end
    end
  end
end

// ==================================================
// limit events
wire [8:0] tnew [0:2];
assign tnew[0] = {temp1_value, 1'b0};
assign tnew[1] = temp2_value;
assign tnew[2] = temp3_value;

reg [2:0] hot_nx;
reg [2:0] ev_t;
always @*
begin
  for (m = 0; m < 3; m = m + 1)
  begin
    if ($signed(tnew[m]) > $signed({ot_lim[m], 1'b0}))
      hot_nx[m] = 1'b1;
    else if ($signed(tnew[m]) < $signed({hyst_limit[m], 1'b0}))
      hot_nx[m] = 1'b0;
    else
      hot_nx[m] = hot[m];
    // two-event mode fires on changes, comparator on every hot sample
    if (tmode[m])
      ev_t[m] = conv_done & (hot_nx[m] ^ hot[m]);
    else
      ev_t[m] = conv_done & hot_nx[m];
  end
end

wire v_now = (volt_value > volt_hi) || (volt_value < volt_lo);
wire ev_v = conv_done & v_now & ~v_out;
wire [1:0] fo_now = {fan_cnt[1] > lim_b, fan_cnt[0] > lim_a};
wire [1:0] ev_f = {2{conv_done}} & (fo_now ^ fan_over);

// clear only once both status registers have been read
wire rda_now = reg_rd && (reg_addr == `R_STAT_A);
wire rdb_now = reg_rd && (reg_addr == `R_STAT_B);
wire both = (rd_a | rda_now) & (rd_b | rdb_now);
wire [2:0] keep_a = both ? 3'h0 : stat_a;
wire [2:0] keep_b = both ? 3'h0 : stat_b;
wire [2:0] ev_a = {ev_f, ev_v};
// a pending bit blocks its own new event, set wins over clear
wire [2:0] new_a = ev_a & ~keep_a;
wire [2:0] new_b = ev_t & ~keep_b;

// ==================================================
// readings, status and interrupt outputs
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    volt_rd <= 8'h00;
    t1_rd <= 8'h00;
    t2_rd <= 9'h000;
    t3_rd <= 9'h000;
    hot <= 3'h0;
    v_out <= 1'b0;
    fan_over <= 2'h0;
    stat_a <= 3'h0;
    stat_b <= 3'h0;
    rd_a <= 1'b0;
    rd_b <= 1'b0;
    sys_mgmt_interrupt_out_n <= 1'b1;
    irq_out <= 1'b0;
  end
  else
  begin
    if (conv_done)
    begin
      volt_rd <= volt_value;
      t1_rd <= temp1_value;
      t2_rd <= temp2_value;
      t3_rd <= temp3_value;
      hot <= hot_nx;
      v_out <= v_now;
      fan_over <= fo_now;
    end
    rd_a <= both ? 1'b0 : (rd_a | rda_now);
    rd_b <= both ? 1'b0 : (rd_b | rdb_now);
    stat_a <= keep_a | ev_a;
    stat_b <= keep_b | ev_t;
    sys_mgmt_interrupt_out_n <= ~(|new_a | |new_b);
    irq_out <= |(keep_a | ev_a) | |(keep_b | ev_t);
  end
end

// ==================================================
// register reads
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
    reg_rdata <= 8'h00;
  else if (reg_rd)
  begin
    case (reg_addr)
      `R_VOLT: reg_rdata <= volt_rd;
      `R_TEMP1: reg_rdata <= t1_rd;
      `R_TEMP2_HI: reg_rdata <= t2_rd[8:1];
      `R_TEMP2_LO: reg_rdata <= {t2_rd[0], 7'h00};
      `R_TEMP3_HI: reg_rdata <= t3_rd[8:1];
      `R_TEMP3_LO: reg_rdata <= {t3_rd[0], 7'h00};
      `R_CNT1: reg_rdata <= fan_cnt[0];
      `R_CNT2: reg_rdata <= fan_cnt[1];
      `R_CNT3: reg_rdata <= fan_cnt[2];
      `R_CNT4: reg_rdata <= fan_cnt[3];
      `R_CNT5: reg_rdata <= fan_cnt[4];
      `R_DUTY1: reg_rdata <= duty[0];
      `R_DUTY2: reg_rdata <= duty[1];
      `R_DUTY3: reg_rdata <= duty[2];
      `R_DUTY4: reg_rdata <= duty[3];
      `R_DUTY5: reg_rdata <= duty[4];
      `R_DIV_A: reg_rdata <= {1'b0, div_sel[1], 1'b0, div_sel[0]};
      `R_DIV_B: reg_rdata <= {1'b0, div_sel[3], 1'b0, div_sel[2]};
      `R_DIV_C: reg_rdata <= {5'h00, div_sel[4]};
      `R_SF_MODE: reg_rdata <= {2'b00, sf_mode};
      `R_WARN: reg_rdata <= {5'h00, fan_full_warn};
      `R_LIM_A: reg_rdata <= lim_a;
      `R_LIM_B: reg_rdata <= lim_b;
      `R_VHI: reg_rdata <= volt_hi;
      `R_VLO: reg_rdata <= volt_lo;
      `R_STAT_A: reg_rdata <= {5'h00, stat_a};
      `R_STAT_B: reg_rdata <= {5'h00, stat_b};
      `R_TMODE: reg_rdata <= {5'h00, tmode};
      default:
      begin
        reg_rdata <= 8'h00;
        for (r = 0; r < 3; r = r + 1)
        begin
          if (reg_addr == `R_TARGET + r)
            reg_rdata <= sf_target[r];
          if (reg_addr == `R_TOL + r)
            reg_rdata <= sf_tol[r];
          if (reg_addr == `R_START + r)
            reg_rdata <= sf_start[r];
          if (reg_addr == `R_FLOOR + r)
            reg_rdata <= sf_floor[r];
          if (reg_addr == `R_OT_LIM + r)
            reg_rdata <= ot_lim[r];
          if (reg_addr == `R_HYST + r)
            reg_rdata <= hyst_limit[r];
        end
      end
    endcase
  end
end

endmodule // fan_thermal_control_alerts

// file: hdl/tach_counter.v
// one tachometer channel: revolution period counter with divisor
`timescale 1ns/1ps
`include "fan_thermal_regs.vh"

module tach_counter (
  input wire mclk, // system clock
  input wire rst_n, // async reset, active low
  input wire base_tick, // 22.5 kHz base rate pulse
  input wire [2:0] div_sel, // divisor is two to this power
  input wire tach_pin, // raw tach pin
  output reg [7:0] count // last revolution count
);

reg s1;
reg s2;
reg s3;
reg half;
reg [6:0] pre;
reg [7:0] run;
wire rise = s2 & ~s3;
wire [7:0] pre_top = (8'h01 << div_sel) - 8'h01;
wire tick = base_tick && ({1'b0, pre} == pre_top);

// ==================================================
// count base ticks over two tach pulses, one revolution
always @(posedge mclk or negedge rst_n)
begin
  if (!rst_n)
  begin
    // tach lines idle high on their pull-ups: no false edge at release
    s1 <= 1'b1;
    s2 <= 1'b1;
    s3 <= 1'b1;
    half <= 1'b0;
    pre <= 7'h00;
    run <= 8'h00;
    count <= 8'h00;
  end
  else
  begin
    s1 <= tach_pin;
    s2 <= s1;
    s3 <= s2;
    if (base_tick)
      pre <= tick ? 7'h00 : pre + 7'h01;
    if (rise)
    begin
      half <= ~half;
      if (half)
      begin
        count <= run;
        run <= 8'h00;
      end
    end
    else if (tick)
    begin
      if (run != `CNT_MAX)
        run <= run + 8'h01;
      else
        count <= `CNT_MAX;
    end
  end
end

endmodule // tach_counter

// file: pkg/fan_thermal_regs.vh
// register map, field layout, reset values and timing of the fan block
`ifndef FAN_THERMAL_REGS_VH
`define FAN_THERMAL_REGS_VH

// ==================================================
// register indices
`define R_VOLT 8'h20
`define R_TEMP1 8'h27
`define R_CNT1 8'h28
`define R_CNT2 8'h29
`define R_CNT3 8'h2A
`define R_CNT4 8'hBA
`define R_CNT5 8'hBB
`define R_VHI 8'h2B
`define R_VLO 8'h2C
`define R_LIM_A 8'h3B
`define R_LIM_B 8'h3C
`define R_STAT_A 8'h41
`define R_STAT_B 8'h42
`define R_DIV_A 8'h47
`define R_DIV_B 8'h4B
`define R_DIV_C 8'h5D
`define R_SF_MODE 8'h5C
`define R_WARN 8'h5E
`define R_DUTY1 8'h81
`define R_DUTY2 8'h83
`define R_DUTY3 8'h94
`define R_DUTY4 8'h9E
`define R_DUTY5 8'h9F
`define R_TARGET 8'h85
`define R_TOL 8'h88
`define R_START 8'h8B
`define R_FLOOR 8'h8E
`define R_TEMP2_HI 8'hC0
`define R_TEMP2_LO 8'hC1
`define R_TEMP3_HI 8'hC8
`define R_TEMP3_LO 8'hC9
`define R_OT_LIM 8'hD0
`define R_HYST 8'hD3
`define R_TMODE 8'hD6

// ==================================================
// fields and reset values
`define DUTY_RESET 8'hFF
`define DIV_RESET 3'h1
`define CNT_MAX 8'hFF
`define PWM_TOP 8'hFE
`define HALF_BIT 7
`define SF_TEMP 2'h1
`define SF_COUNT 2'h2

// ==================================================
// timing
`define CLK_PERIOD_NS 25
`define TACH_TICK_NS 44444
`define TACH_TICK_CYCLES (`TACH_TICK_NS / `CLK_PERIOD_NS)
`define STEP_TIME_MS 100
`define STEP_CYCLES (`STEP_TIME_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// file: test/fan_tach_model.sv
// behavioural fans driving the five tachometer lines
`timescale 1ns/1ps

module fan_tach_model (
  input wire mclk, // clock
  input wire rst_n, // reset, active low
  input wire [15:0] half_per, // cycles per half pulse, 0 = stopped
  output logic [4:0] tach_in // tach lines
);
  logic [15:0] cnt;
  // ====================
  // pulse train
  // a stopped fan leaves the pulled-up line high, not the last level
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 16'h0000;
      tach_in <= 5'h1F;
    end
    else if (half_per == 16'h0000)
      tach_in <= 5'h1F;
    else if (cnt == half_per - 16'h0001)
    begin
      cnt <= 16'h0000;
      tach_in <= ~tach_in;
    end
    else
      cnt <= cnt + 16'h0001;
  end
endmodule // fan_tach_model

// file: test/fan_thermal_control_alerts_assertions.sv
// port checker for the fan and thermal alert block
`timescale 1ns/1ps

module fan_thermal_control_alerts_assertions #(
  parameter [23:0] STEP_CYCLES = 16
) (
  input wire mclk, // clock
  input wire rst_n, // reset, active low
  input wire [7:0] reg_addr, // index
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire conv_done, // conversion pulse
  input wire [7:0] temp1_value, // sensor one
  input wire [8:0] temp2_value, // sensor two
  input wire [4:0] fan_drive_out, // drive pins
  input wire sys_mgmt_interrupt_out_n, // event pulse
  input wire irq_out, // level interrupt
  input wire [2:0] fan_full_warn // full duty warnings
);
  // ====================
  // sequences
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] t1_seen;
  logic [8:0] t2_seen;
  // readings are latched per conversion, not live inputs
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t1_seen <= 8'h00;
      t2_seen <= 9'h000;
    end
    else if (conv_done)
    begin
      t1_seen <= temp1_value;
      t2_seen <= temp2_value;
    end
  end
  sequence alert_pulse;
    !sys_mgmt_interrupt_out_n ##1 sys_mgmt_interrupt_out_n;
  endsequence
  sequence full_drive;
    (fan_drive_out == 5'h1F) [*8];
  endsequence
  // ====================
  // checks
  a_alert_one_cycle: assert property (
    $fell(sys_mgmt_interrupt_out_n) |-> alert_pulse)
    else $error("event pulse not one cycle");
  a_alert_after_conv: assert property (
    $fell(sys_mgmt_interrupt_out_n) |-> $past(conv_done))
    else $error("event pulse without conversion");
  a_irq_clear_read: assert property (
    $fell(irq_out) |-> $past(reg_rd) &&
    ($past(reg_addr) == 8'h41 || $past(reg_addr) == 8'h42))
    else $error("level interrupt dropped without status read");
  a_reset_full_drive: assert property (
    $rose(rst_n) |-> full_drive)
    else $error("drives not full after reset");
  a_warn_full_drive: assert property (
    (fan_full_warn & ~fan_drive_out[2:0]) == 3'h0)
    else $error("warning while drive not full");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_temp1_read: assert property (
    reg_rd && reg_addr == 8'h27 |=> reg_rdata == $past(t1_seen))
    else $error("sensor one reading wrong");
  a_temp2_read: assert property (
    reg_rd && reg_addr == 8'hC0 |=>
    {1'b0, reg_rdata} == ($past(t2_seen) >> 1))
    else $error("sensor two upper byte wrong");
endmodule // fan_thermal_control_alerts_assertions

bind fan_thermal_control_alerts fan_thermal_control_alerts_assertions #(
  .STEP_CYCLES(STEP_CYCLES)
) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_done(conv_done),
  .temp1_value(temp1_value), .temp2_value(temp2_value),
  .fan_drive_out(fan_drive_out),
  .sys_mgmt_interrupt_out_n(sys_mgmt_interrupt_out_n),
  .irq_out(irq_out), .fan_full_warn(fan_full_warn)
);

// file: test/fan_thermal_control_alerts_bench.sv
// self-checking bench for the fan and thermal alert block
`timescale 1ns/1ps
`include "fan_thermal_regs.vh"

module fan_thermal_control_alerts_bench;
  localparam int HALF = 3554;
  localparam int CNT_EXP = 4 * HALF / (2 * `TACH_TICK_CYCLES);
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, conv_done = 1'b0, s;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, volt_value = 8'h00;
  logic [7:0] temp1_value = 8'hE7, reg_rdata, d0, d1;
  logic [8:0] temp2_value = 9'h1CE, temp3_value = 9'h001;
  logic [4:0] tach_in, fan_drive_out;
  logic sys_mgmt_interrupt_out_n, irq_out;
  logic [2:0] fan_full_warn;
  logic [15:0] rows [14] = '{16'h81FF, 16'h83FF, 16'h94FF, 16'h9EFF,
    16'h9FFF, 16'h4711, 16'h3BFF, 16'h3CFF, 16'h0100, 16'h27E7,
    16'hC0E7, 16'hC100, 16'hC800, 16'hC980};
  logic [7:0] pv [3] = '{8'h00, 8'h80, 8'hFE};
  int mismatches = 0;
  int checked = 0;
  logic [7:0] n;

  always #12.5 mclk = ~mclk;

  fan_tach_model u_fans (.mclk(mclk), .rst_n(rst_n),
    .half_per(16'(HALF)), .tach_in(tach_in));

  fan_thermal_control_alerts #(.STEP_CYCLES(24'h000010)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tach_in(tach_in), .conv_done(conv_done),
    .volt_value(volt_value), .temp1_value(temp1_value),
    .temp2_value(temp2_value), .temp3_value(temp3_value),
    .fan_drive_out(fan_drive_out),
    .sys_mgmt_interrupt_out_n(sys_mgmt_interrupt_out_n),
    .irq_out(irq_out), .fan_full_warn(fan_full_warn));

  // ====================
  // bus and check tasks
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] v, e);
    checked++;
    if (v !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  // strobes drop one cycle before the next access may raise them
  task automatic wr(input logic [7:0] a, v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    d = reg_rdata;
    tick();
  endtask
  task automatic rchk(input logic [7:0] a, e);
    rd(a, d1);
    chk("register read", d1, e);
  endtask
  task automatic clr();
    rd(`R_STAT_A, d0);
    rd(`R_STAT_B, d0);
  endtask
  // either edge after the pulse is accepted for the low event cycle
  task automatic conv(input logic ev);
    conv_done = 1'b1;
    tick();
    s = sys_mgmt_interrupt_out_n;
    conv_done = 1'b0;
    tick();
    s = s & sys_mgmt_interrupt_out_n;
    chk("event pulse", 8'(s), 8'(!ev));
  endtask
  // reads 64 cycles apart span exactly four loop steps
  task automatic ramp(input logic [7:0] a, e);
    rd(a, d0);
    repeat (62) tick();
    rd(a, d1);
    chk("duty step", d1 - d0, e);
  endtask
  task automatic results();
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #2_000_000;
    mismatches++;
    results();
  end

  // ====================
  // main sequence
  initial
  begin
    repeat (3) tick();
    rst_n = 1'b1;
    tick();
    conv(1'b0);
    foreach (rows[i])
      rchk(rows[i][15:8], rows[i][7:0]);
    // fan five divides by four, so its count halves
    wr(`R_DIV_C, 8'h02);
    repeat (45000) tick();
    rchk(`R_CNT1, 8'(CNT_EXP));
    rchk(`R_CNT5, 8'(CNT_EXP / 2));
    wr(`R_TARGET, 8'h32);
    wr(`R_TOL, 8'h03);
    wr(`R_START, 8'hC0);
    wr(`R_FLOOR, 8'h10);
    wr(`R_SF_MODE, 8'h01);
    temp1_value = 8'h28;
    conv(1'b0);
    repeat (40) tick();
    rchk(`R_DUTY1, 8'h10);
    temp1_value = 8'h3C;
    conv(1'b0);
    repeat (20) tick();
    rd(`R_DUTY1, d0);
    chk("start duty", 8'(d0 inside {8'hC0, 8'hC1}), 8'h01);
    ramp(`R_DUTY1, 8'h04);
    temp1_value = 8'h32;
    conv(1'b0);
    ramp(`R_DUTY1, 8'h00);
    temp1_value = 8'h28;
    conv(1'b0);
    ramp(`R_DUTY1, 8'hFC);
    temp1_value = 8'h3C;
    conv(1'b0);
    repeat (1100) tick();
    chk("full warning", 8'(fan_full_warn), 8'h01);
    temp1_value = 8'h28;
    conv(1'b0);
    repeat (4200) tick();
    rchk(`R_DUTY1, 8'h10);
    rchk(`R_DUTY2, 8'hFF);
    wr(`R_SF_MODE, 8'h08);
    rchk(`R_CNT2, 8'(CNT_EXP));
    wr(8'h86, 8'h0A);
    wr(8'h89, 8'h02);
    ramp(`R_DUTY2, 8'hFC);
    wr(8'h86, 8'h02);
    wr(8'h89, 8'h01);
    ramp(`R_DUTY2, 8'h04);
    wr(8'h86, 8'h04);
    ramp(`R_DUTY2, 8'h00);
    wr(`R_SF_MODE, 8'h00);
    foreach (pv[i])
    begin
      wr(`R_DUTY4, pv[i]);
      n = 0;
      repeat (255)
      begin
        tick();
        n += fan_drive_out[3];
      end
      chk("drive high time", 8'(n), pv[i]);
    end
    wr(`R_VHI, 8'h80);
    wr(`R_VLO, 8'h20);
    volt_value = 8'h50;
    conv(1'b0);
    volt_value = 8'h90;
    conv(1'b1);
    conv(1'b0);
    chk("level interrupt", 8'(irq_out), 8'h01);
    rchk(`R_STAT_A, 8'h01);
    rd(`R_STAT_B, d0);
    chk("level interrupt", 8'(irq_out), 8'h00);
    volt_value = 8'h50;
    conv(1'b0);
    volt_value = 8'h10;
    conv(1'b1);
    clr();
    wr(`R_LIM_A, 8'h02);
    conv(1'b1);
    rchk(`R_STAT_A, 8'h02);
    rd(`R_STAT_B, d0);
    wr(`R_LIM_A, 8'hFF);
    conv(1'b1);
    clr();
    wr(`R_OT_LIM, 8'h32);
    wr(`R_HYST, 8'h28);
    temp1_value = 8'h3C;
    conv(1'b1);
    conv(1'b0);
    rd(`R_STAT_A, d0);
    rchk(`R_STAT_B, 8'h01);
    conv(1'b1);
    clr();
    temp1_value = 8'h23;
    conv(1'b0);
    wr(`R_TMODE, 8'h01);
    temp1_value = 8'h3C;
    conv(1'b1);
    clr();
    conv(1'b0);
    temp1_value = 8'h23;
    conv(1'b1);
    clr();
    rst_n = 1'b0;
    repeat (3) tick();
    chk("drive in reset", 8'(fan_drive_out), 8'h1F);
    rst_n = 1'b1;
    tick();
    rchk(`R_DUTY4, 8'hFF);
    results();
  end
endmodule // fan_thermal_control_alerts_bench
